// ==== psf_pin_mux.v ====
// Pin shared function multiplexer with port registers and AHB-Lite register slave
//
// Overview of operation
// - Port A bit 3 field: codes 00,01,10 give GPIO, 11 gives current sink 1.
// - Port A bit 2 field: GPIO, scan common 3, I2C SCL, cascade serial out.
// - Port A bit 1 field: codes 00,01,10 give GPIO, 11 gives current sink 0.
// - Port A bit 0 field: GPIO, GPIO, I2C SDA, cascade serial input.
// - Port B bit 3 field: GPIO, scan common 0, GPIO, current sink 9.
// - Port B bit 2 field: codes 00,01,10 give GPIO, 11 gives current sink 8.
// - Port B bit 1 field: GPIO, GPIO, I2C SDA, current sink 7.
// - Port B bit 0 field: GPIO, GPIO, I2C SCL, current sink 6.
// - Port B bit 5 field: GPIO, scan common 2, cascade serial in, sink 11.
// - Port B bit 4 field: GPIO, scan common 1, cascade serial out, sink 10.
// - Input source bit 2 picks SDA input: port A bit 0 or port B bit 1.
// - Input source bit 1 picks SCL input: port A bit 2 or port B bit 0.
// - Input source bit 0 picks cascade input: port A bit 0 or port B bit 5.
// - Reset sets every port data and direction bit high: all pins inputs.
// - Output enabled without prior data write drives high from the reset latch.
// - Bit set and clear read the whole port, modify, write back the byte.
// - In sleep, falling edge on a wake-enabled port A GPIO input pin wakes the device.
// - Direction bit 1 makes the pin input, 0 makes it a CMOS output.
`timescale 1ns/1ps
`include "psf_regs.vh"

module psf_pin_mux #(
	parameter PA_W = 8,
	parameter PB_W = 6
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             hsel,
	input  wire [31:0]      haddr,
	input  wire [1:0]       htrans,
	input  wire             hwrite,
	input  wire [2:0]       hsize,
	input  wire [31:0]      hwdata,
	input  wire             hready,
	output reg  [31:0]      hrdata,
	output reg              hreadyout,
	output reg              hresp,
	input  wire [PA_W-1:0]  pa_in,
	output reg  [PA_W-1:0]  pa_out,
	output reg  [PA_W-1:0]  pa_oe,
	input  wire [PB_W-1:0]  pb_in,
	output reg  [PB_W-1:0]  pb_out,
	output reg  [PB_W-1:0]  pb_oe,
	input  wire [3:0]       scan_common,
	input  wire [11:0]      current_sink_out,
	input  wire             i2c_scl_out,
	input  wire             i2c_scl_oe,
	input  wire             i2c_sda_out,
	input  wire             i2c_sda_oe,
	input  wire             cascade_serial_out,
	output reg              i2c_scl_in,
	output reg              i2c_sda_in,
	output reg              cascade_serial_in,
	input  wire             sleep_mode,
	output reg              wake_req
);

	reg [7:0]       port_a_low_selector_ff;
	reg [7:0]       port_a_high_selector_ff;
	reg [7:0]       port_b_low_selector_ff;
	reg [3:0]       port_b_high_selector_ff;
	reg [2:0]       input_source_selector_ff;
	reg [PA_W-1:0]  pa_data_ff;
	reg [PA_W-1:0]  pa_dir_ff;
	reg [PA_W-1:0]  port_a_wake_enable_ff;
	reg [PB_W-1:0]  pb_data_ff;
	reg [PB_W-1:0]  pb_dir_ff;
	reg [PA_W-1:0]  pa_prev_ff;
	reg             wr_pend_ff;
	reg [7:0]       addr_ff;
	reg [31:0]      rd_mux;
	reg [PA_W-1:0]  pa_data_rmw;
	reg [PB_W-1:0]  pb_data_rmw;
	reg [PA_W-1:0]  nxt_pa_out;
	reg [PA_W-1:0]  nxt_pa_oe;
	reg [PB_W-1:0]  nxt_pb_out;
	reg [PB_W-1:0]  nxt_pb_oe;
	reg [PA_W-1:0]  pa_gpio_in;
	reg [PB_W-1:0]  pb_gpio_in;
	reg [PA_W-1:0]  pa_gpio_sel;
	wire            take;
	wire            bit_set;
	wire [2:0]      bit_idx;
	wire [1:0]      sel_pa0;
	wire [1:0]      sel_pa1;
	wire [1:0]      sel_pa2;
	wire [1:0]      sel_pa3;
	wire [1:0]      sel_pb0;
	wire [1:0]      sel_pb1;
	wire [1:0]      sel_pb2;
	wire [1:0]      sel_pb3;
	wire [1:0]      sel_pb4;
	wire [1:0]      sel_pb5;
	wire [PA_W-1:0] pa_fall;
	wire [3:0]      pa_hi_sink;

	assign take    = hsel & hready & htrans[1];
	assign bit_set = hwdata[`PSF_BITOP_SET_BIT];
	assign bit_idx = hwdata[`PSF_BITOP_IDX_LSB+2:`PSF_BITOP_IDX_LSB];

	assign sel_pa0 = port_a_low_selector_ff[1:0];
	assign sel_pa1 = port_a_low_selector_ff[3:2];
	assign sel_pa2 = port_a_low_selector_ff[5:4];
	assign sel_pa3 = port_a_low_selector_ff[7:6];
	assign sel_pb0 = port_b_low_selector_ff[1:0];
	assign sel_pb1 = port_b_low_selector_ff[3:2];
	assign sel_pb2 = port_b_low_selector_ff[5:4];
	assign sel_pb3 = port_b_low_selector_ff[7:6];
	assign sel_pb4 = port_b_high_selector_ff[1:0];
	assign sel_pb5 = port_b_high_selector_ff[3:2];

	// Port A upper pins: code 11 hands each pin to current sinks 2 to 5,
	// every other code leaves the pin to the port
	genvar gk;
	generate
		for (gk = 0; gk < 4; gk = gk + 1) begin : g_hi_sink
			assign pa_hi_sink[gk] = (port_a_high_selector_ff[2*gk+1:2*gk] == `PSF_CODE_ALT3);
		end
	endgenerate

	// Wake-up only works on pins whose field still selects the port bit
	always @* begin
		pa_gpio_sel      = {PA_W{1'b1}};
		pa_gpio_sel[0]   = (sel_pa0 == `PSF_CODE_GPIO) | (sel_pa0 == `PSF_CODE_ALT1);
		pa_gpio_sel[1]   = (sel_pa1 != `PSF_CODE_ALT3);
		pa_gpio_sel[2]   = (sel_pa2 == `PSF_CODE_GPIO);
		pa_gpio_sel[3]   = (sel_pa3 != `PSF_CODE_ALT3);
		pa_gpio_sel[7:4] = ~pa_hi_sink;
	end

	// Bit operations read the whole port (pads for inputs, latch for outputs),
	// change one bit and write the full byte back, so input pins take their pad level
	always @* begin
		pa_data_rmw = pa_gpio_in;
		pb_data_rmw = pb_gpio_in;
		pa_data_rmw[bit_idx] = bit_set;
		if (bit_idx < PB_W)
			pb_data_rmw[bit_idx] = bit_set;
	end

	// AHB-Lite slave: zero wait states, always OKAY
	// Reads decode the address phase, so data already stands in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			hrdata     <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= take & hwrite;
			if (take)
				addr_ff <= haddr[7:0];
			if (take & ~hwrite)
				hrdata <= rd_mux;
		end
	end

	// Unmapped offsets and unimplemented bits read as zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			`PSF_OFF_PA_LO_SEL: rd_mux[7:0] = port_a_low_selector_ff;
			`PSF_OFF_PA_HI_SEL: rd_mux[7:0] = port_a_high_selector_ff;
			`PSF_OFF_PB_LO_SEL: rd_mux[7:0] = port_b_low_selector_ff;
			`PSF_OFF_PB_HI_SEL: rd_mux[3:0] = port_b_high_selector_ff;
			`PSF_OFF_IN_SRC:    rd_mux[2:0] = input_source_selector_ff;
			`PSF_OFF_PA_DATA:   rd_mux[PA_W-1:0] = pa_data_ff;
			`PSF_OFF_PA_DIR:    rd_mux[PA_W-1:0] = pa_dir_ff;
			`PSF_OFF_PA_WAKE:   rd_mux[PA_W-1:0] = port_a_wake_enable_ff;
			`PSF_OFF_PB_DATA:   rd_mux[PB_W-1:0] = pb_data_ff;
			`PSF_OFF_PB_DIR:    rd_mux[PB_W-1:0] = pb_dir_ff;
			`PSF_OFF_SLEEP:     rd_mux[0] = wake_req;
			`PSF_OFF_PA_PIN:    rd_mux[PA_W-1:0] = pa_gpio_in;
			`PSF_OFF_PB_PIN:    rd_mux[PB_W-1:0] = pb_gpio_in;
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// Pin readback: inputs show the pad, outputs show the latch
	always @* begin
		pa_gpio_in = (pa_in & pa_dir_ff) | (pa_data_ff & ~pa_dir_ff);
		pb_gpio_in = (pb_in & pb_dir_ff) | (pb_data_ff & ~pb_dir_ff);
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Writes land in the data phase, when hwdata is valid
			port_a_low_selector_ff   <= `PSF_RST_SEL;
			port_a_high_selector_ff  <= `PSF_RST_SEL;
			port_b_low_selector_ff   <= `PSF_RST_SEL;
			port_b_high_selector_ff  <= 4'h0;
			input_source_selector_ff <= 3'h0;
			pa_data_ff               <= `PSF_RST_PA_PORT;
			pa_dir_ff                <= `PSF_RST_PA_PORT;
			port_a_wake_enable_ff    <= 8'h00;
			pb_data_ff               <= `PSF_RST_PB_PORT;
			pb_dir_ff                <= `PSF_RST_PB_PORT;
		end else if (wr_pend_ff) begin
			case (addr_ff)
				`PSF_OFF_PA_LO_SEL: port_a_low_selector_ff <= hwdata[7:0];
				`PSF_OFF_PA_HI_SEL: port_a_high_selector_ff <= hwdata[7:0];
				`PSF_OFF_PB_LO_SEL: port_b_low_selector_ff <= hwdata[7:0];
				`PSF_OFF_PB_HI_SEL: port_b_high_selector_ff <= hwdata[3:0];
				`PSF_OFF_IN_SRC:    input_source_selector_ff <= hwdata[2:0];
				`PSF_OFF_PA_DATA:   pa_data_ff <= hwdata[PA_W-1:0];
				`PSF_OFF_PA_DIR:    pa_dir_ff <= hwdata[PA_W-1:0];
				`PSF_OFF_PA_WAKE:   port_a_wake_enable_ff <= hwdata[PA_W-1:0];
				`PSF_OFF_PB_DATA:   pb_data_ff <= hwdata[PB_W-1:0];
				`PSF_OFF_PB_DIR:    pb_dir_ff <= hwdata[PB_W-1:0];
				`PSF_OFF_PA_BITOP:  pa_data_ff <= pa_data_rmw;
				`PSF_OFF_PB_BITOP: begin
					// An index beyond port B changes nothing
					if (bit_idx < PB_W)
						pb_data_ff <= pb_data_rmw;
				end
				default: ;
			endcase
		end
	end

	// Output mux; peripheral owners take over the latch, GPIO follows direction bit
	always @* begin
		nxt_pa_out = pa_data_ff;
		nxt_pa_oe  = ~pa_dir_ff;
		nxt_pb_out = pb_data_ff;
		nxt_pb_oe  = ~pb_dir_ff;
		case (sel_pa0)
			`PSF_CODE_ALT2: begin
				nxt_pa_out[0] = i2c_sda_out;
				nxt_pa_oe[0]  = i2c_sda_oe;
			end
			`PSF_CODE_ALT3: nxt_pa_oe[0] = 1'b0;
			default: ;
		endcase
		if (sel_pa1 == `PSF_CODE_ALT3) begin
			nxt_pa_out[1] = current_sink_out[0];
			nxt_pa_oe[1]  = 1'b1;
		end
		case (sel_pa2)
			`PSF_CODE_ALT1: begin
				nxt_pa_out[2] = scan_common[3];
				nxt_pa_oe[2]  = 1'b1;
			end
			`PSF_CODE_ALT2: begin
				nxt_pa_out[2] = i2c_scl_out;
				nxt_pa_oe[2]  = i2c_scl_oe;
			end
			`PSF_CODE_ALT3: begin
				nxt_pa_out[2] = cascade_serial_out;
				nxt_pa_oe[2]  = 1'b1;
			end
			default: ;
		endcase
		if (sel_pa3 == `PSF_CODE_ALT3) begin
			nxt_pa_out[3] = current_sink_out[1];
			nxt_pa_oe[3]  = 1'b1;
		end
		// Upper port A pins given to a current sink drive it in place of the latch
		nxt_pa_out[7:4] = (nxt_pa_out[7:4] & ~pa_hi_sink) | (current_sink_out[5:2] & pa_hi_sink);
		nxt_pa_oe[7:4]  = nxt_pa_oe[7:4] | pa_hi_sink;
		case (sel_pb0)
			`PSF_CODE_ALT2: begin
				nxt_pb_out[0] = i2c_scl_out;
				nxt_pb_oe[0]  = i2c_scl_oe;
			end
			`PSF_CODE_ALT3: begin
				nxt_pb_out[0] = current_sink_out[6];
				nxt_pb_oe[0]  = 1'b1;
			end
			default: ;
		endcase
		case (sel_pb1)
			`PSF_CODE_ALT2: begin
				nxt_pb_out[1] = i2c_sda_out;
				nxt_pb_oe[1]  = i2c_sda_oe;
			end
			`PSF_CODE_ALT3: begin
				nxt_pb_out[1] = current_sink_out[7];
				nxt_pb_oe[1]  = 1'b1;
			end
			default: ;
		endcase
		if (sel_pb2 == `PSF_CODE_ALT3) begin
			nxt_pb_out[2] = current_sink_out[8];
			nxt_pb_oe[2]  = 1'b1;
		end
		case (sel_pb3)
			`PSF_CODE_ALT1: begin
				nxt_pb_out[3] = scan_common[0];
				nxt_pb_oe[3]  = 1'b1;
			end
			`PSF_CODE_ALT3: begin
				nxt_pb_out[3] = current_sink_out[9];
				nxt_pb_oe[3]  = 1'b1;
			end
			default: ;
		endcase
		case (sel_pb4)
			`PSF_CODE_ALT1: begin
				nxt_pb_out[4] = scan_common[1];
				nxt_pb_oe[4]  = 1'b1;
			end
			`PSF_CODE_ALT2: begin
				nxt_pb_out[4] = cascade_serial_out;
				nxt_pb_oe[4]  = 1'b1;
			end
			`PSF_CODE_ALT3: begin
				nxt_pb_out[4] = current_sink_out[10];
				nxt_pb_oe[4]  = 1'b1;
			end
			default: ;
		endcase
		case (sel_pb5)
			`PSF_CODE_ALT1: begin
				nxt_pb_out[5] = scan_common[2];
				nxt_pb_oe[5]  = 1'b1;
			end
			`PSF_CODE_ALT2: nxt_pb_oe[5] = 1'b0;
			`PSF_CODE_ALT3: begin
				nxt_pb_out[5] = current_sink_out[11];
				nxt_pb_oe[5]  = 1'b1;
			end
			default: ;
		endcase
	end

	// Wake only counts on pins that are GPIO inputs; pins driven by a peripheral are ignored
	genvar gi;
	generate
		for (gi = 0; gi < PA_W; gi = gi + 1) begin : g_fall
			assign pa_fall[gi] = pa_prev_ff[gi] & ~pa_in[gi] & pa_dir_ff[gi] & pa_gpio_sel[gi] &
				port_a_wake_enable_ff[gi];
		end
	endgenerate

	// Pads and routed inputs come from flip-flops; routing costs one cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pa_out            <= `PSF_RST_PA_PORT;
			pa_oe             <= 8'h00;
			pb_out            <= `PSF_RST_PB_PORT;
			pb_oe             <= 6'h00;
			i2c_scl_in        <= 1'b1;
			i2c_sda_in        <= 1'b1;
			cascade_serial_in <= 1'b0;
			pa_prev_ff        <= `PSF_RST_PA_PORT;
			wake_req          <= 1'b0;
		end else begin
			pa_out <= nxt_pa_out;
			pa_oe  <= nxt_pa_oe;
			pb_out <= nxt_pb_out;
			pb_oe  <= nxt_pb_oe;
			i2c_sda_in <= input_source_selector_ff[`PSF_IFS_SDA_BIT] ? pb_in[1] : pa_in[0];
			i2c_scl_in <= input_source_selector_ff[`PSF_IFS_SCL_BIT] ? pb_in[0] : pa_in[2];
			cascade_serial_in <= input_source_selector_ff[`PSF_IFS_CAS_BIT] ? pb_in[5] : pa_in[0];
			pa_prev_ff <= pa_in;
			// Pulse holds until sleep ends, so a slow power controller cannot miss it
			if (!sleep_mode)
				wake_req <= 1'b0;
			else if (|pa_fall)
				wake_req <= 1'b1;
		end
	end

endmodule // psf_pin_mux

// ==== psf_pin_mux_asserts.sv ====
// Port-level assertions for the pin function multiplexer
`timescale 1ns/1ps
module psf_pin_mux_asserts #(
	parameter PA_W = 8,
	parameter PB_W = 6
) (
	input wire            hclk,
	input wire            hresetn,
	input wire [31:0]     hrdata,
	input wire [PA_W-1:0] pa_in,
	input wire [PA_W-1:0] pa_out,
	input wire [PA_W-1:0] pa_oe,
	input wire [PB_W-1:0] pb_in,
	input wire [PB_W-1:0] pb_out,
	input wire [PB_W-1:0] pb_oe,
	input wire            i2c_scl_in,
	input wire            i2c_sda_in,
	input wire            cascade_serial_in,
	input wire            sleep_mode,
	input wire            wake_req
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_read_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
	// Routed inputs are registered, so they follow one of the two candidate pads of the previous edge
	a_sda_source: assert property ($past(hresetn) |-> i2c_sda_in == $past(pa_in[0]) ||
		i2c_sda_in == $past(pb_in[1])) else $error("sda input from no source pin");
	a_scl_source: assert property ($past(hresetn) |-> i2c_scl_in == $past(pa_in[2]) ||
		i2c_scl_in == $past(pb_in[0])) else $error("scl input from no source pin");
	a_cascade_source: assert property ($past(hresetn) |-> cascade_serial_in == $past(pa_in[0]) ||
		cascade_serial_in == $past(pb_in[5])) else $error("cascade input from no source pin");
	a_reset_pins_input: assert property ($rose(hresetn) |-> pa_oe == 0 && pb_oe == 0 &&
		pa_out == {PA_W{1'b1}} && pb_out == {PB_W{1'b1}}) else $error("pins not released high after reset");
	a_wake_sleep_only: assert property (!$past(sleep_mode) |-> !wake_req) else $error("wake outside sleep");
	a_wake_needs_fall: assert property ($rose(wake_req) |-> $past(sleep_mode) &&
		((|($past(pa_in, 2) & ~$past(pa_in))) || (|($past(pa_in, 3) & ~$past(pa_in, 2)))))
		else $error("wake without a falling port a pin");
	a_wake_holds: assert property (wake_req && sleep_mode |=> wake_req) else $error("wake dropped in sleep");
	c_wake: cover property ($rose(wake_req));
	c_sda_route: cover property ($rose(i2c_sda_in));
	c_pa_drive: cover property ($rose(pa_oe[0]));
endmodule // psf_pin_mux_asserts

bind psf_pin_mux psf_pin_mux_asserts #(.PA_W(PA_W), .PB_W(PB_W)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hrdata(hrdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
	.pb_oe(pb_oe), .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in), .cascade_serial_in(cascade_serial_in),
	.sleep_mode(sleep_mode), .wake_req(wake_req));

// ==== psf_pin_mux_tb.sv ====
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`include "psf_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        hclk = 0;
	logic        hresetn = 0;
	logic        hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata, q;
	logic        hreadyout, hresp, scl_i, sda_i, cas_i, wake_req;
	logic [7:0]  pa_in = 8'h05;
	logic [7:0]  pa_out, pa_oe;
	logic [5:0]  pb_in = 6'h00;
	logic [5:0]  pb_out, pb_oe;
	logic        po = 1;
	logic        pe = 0;
	logic        sleep_mode = 0;
	int          failures = 0;
	int          checks = 0;
	int          i;
	// Peripheral levels are chosen opposite to the port latch, except SDA on port B bit 1 and sinks on port A bits 5 and 7, so a missed override shows
	logic [7:0]  ra [11] = '{`PSF_OFF_PA_LO_SEL, `PSF_OFF_PA_HI_SEL, `PSF_OFF_PB_LO_SEL, `PSF_OFF_PB_HI_SEL,
		`PSF_OFF_IN_SRC, `PSF_OFF_PA_WAKE, `PSF_OFF_PA_DATA, `PSF_OFF_PA_DIR, `PSF_OFF_PB_DATA, `PSF_OFF_PB_DIR, 8'h3C};
	logic [7:0]  rv [11] = '{0, 0, 0, 0, 0, 0, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 0};
	logic [7:0]  xa [4] = '{8'hFA, 8'hFE, 8'hFF, 8'hE4};
	logic [11:0] xb [4] = '{12'hFEA, 12'hFD2, 12'h7DB, 12'hFD5};
	always #2 hclk = ~hclk;
	psf_pin_mux dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in),
		.pb_out(pb_out), .pb_oe(pb_oe), .scan_common(4'hA), .current_sink_out(12'h540), .i2c_scl_out(po),
		.i2c_scl_oe(pe), .i2c_sda_out(po), .i2c_sda_oe(pe), .cascade_serial_out(po), .i2c_scl_in(scl_i),
		.i2c_sda_in(sda_i), .cascade_serial_in(cas_i), .sleep_mode(sleep_mode), .wake_req(wake_req));
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, q)
	endtask
	task automatic settle;
		repeat (2) @(posedge hclk);
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 11; i++) rchk(ra[i], rv[i], "reset value");
		`CHK("oe reset", 14'h0, {pa_oe, pb_oe})
		$display("done reset");
		bus(1'b1, `PSF_OFF_PA_DIR, 32'h0);
		bus(1'b1, `PSF_OFF_PB_DIR, 32'h0);
		settle;
		`CHK("pins high", 28'hFFFFFFF, {pa_oe, pa_out, pb_oe, pb_out})
		bus(1'b1, `PSF_OFF_PA_DATA, 32'h5A);
		bus(1'b1, `PSF_OFF_PB_DATA, 32'h2A);
		settle;
		`CHK("latch", 14'h16AA, {pa_out, pb_out})
		$display("done direction");
		for (i = 0; i < 4; i++) begin
			bus(1'b1, `PSF_OFF_PA_LO_SEL, i * 32'h55);
			bus(1'b1, `PSF_OFF_PB_LO_SEL, i * 32'h55);
			bus(1'b1, `PSF_OFF_PB_HI_SEL, i * 32'h05);
			@(posedge hclk) pe <= (i == 2);
			settle;
			`CHK("port a mux", xa[i], {pa_oe[3:0], pa_out[3:0] & pa_oe[3:0]})
			`CHK("port b mux", xb[i], {pb_oe, pb_out & pb_oe})
			if (i == 2) begin
				@(posedge hclk) po <= 1'b0;
				settle;
				`CHK("follow a", 8'hFA, {pa_oe[3:0], pa_out[3:0] & pa_oe[3:0]})
				`CHK("follow b", 12'h7C8, {pb_oe, pb_out & pb_oe})
				@(posedge hclk);
				po <= 1'b1;
				pe <= 1'b0;
				settle;
				`CHK("release a", 8'hAA, {pa_oe[3:0], pa_out[3:0] & pa_oe[3:0]})
				`CHK("release b", 12'h718, {pb_oe, pb_out & pb_oe})
			end
		end
		bus(1'b1, `PSF_OFF_PA_HI_SEL, 32'hFF);
		settle;
		`CHK("port a sinks", 8'hF0, {pa_oe[7:4], pa_out[7:4]})
		bus(1'b1, `PSF_OFF_PA_HI_SEL, 32'h00);
		$display("done mux");
		bus(1'b1, `PSF_OFF_PB_HI_SEL, 32'hFF);
		rchk(`PSF_OFF_PB_HI_SEL, 32'h0F, "pb high mask");
		bus(1'b1, `PSF_OFF_PA_DIR, 32'hFF);
		bus(1'b1, `PSF_OFF_PB_DIR, 32'h3F);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, `PSF_OFF_IN_SRC, 32'hF8 | i);
			settle;
			`CHK("input routes", ~i[2:0], {sda_i, scl_i, cas_i})
		end
		rchk(`PSF_OFF_IN_SRC, 32'h07, "input source mask");
		$display("done routing");
		bus(1'b1, `PSF_OFF_PA_DIR, 32'hF0);
		rchk(`PSF_OFF_PA_PIN, 32'h0A, "port a pins");
		rchk(`PSF_OFF_PB_PIN, 32'h00, "port b pins");
		bus(1'b1, `PSF_OFF_PA_BITOP, 32'h003);
		bus(1'b1, `PSF_OFF_PA_BITOP, 32'h100);
		bus(1'b1, `PSF_OFF_PB_BITOP, 32'h106);
		rchk(`PSF_OFF_PA_DATA, 32'h03, "bit ops a");
		rchk(`PSF_OFF_PB_DATA, 32'h2A, "bit ops b");
		bus(1'b1, `PSF_OFF_PB_BITOP, 32'h104);
		rchk(`PSF_OFF_PB_DATA, 32'h10, "bit ops b pad");
		$display("done bit ops");
		bus(1'b1, `PSF_OFF_PA_DIR, 32'hFF);
		bus(1'b1, `PSF_OFF_PA_WAKE, 32'h10);
		@(posedge hclk) sleep_mode <= 1'b1;
		@(posedge hclk) pa_in <= 8'h15;
		settle;
		// A fall on a pin without wake enable must be ignored
		@(posedge hclk) pa_in <= 8'h14;
		settle;
		settle;
		`CHK("no wake", 1'b0, wake_req)
		@(posedge hclk) pa_in <= 8'h04;
		i = 0;
		while (wake_req !== 1'b1 && i < 6) begin
			@(posedge hclk);
			i++;
		end
		`CHK("wake", 1'b1, wake_req)
		rchk(`PSF_OFF_SLEEP, 32'h1, "wake status");
		@(posedge hclk) sleep_mode <= 1'b0;
		settle;
		`CHK("wake clear", 1'b0, wake_req)
		$display("done wake");
		close_out;
	end
endmodule // testbench

// ==== psf_regs.vh ====
// Register offsets, field positions and reset values of the pin function multiplexer
`ifndef PSF_REGS_VH
`define PSF_REGS_VH
`define PSF_OFF_PA_LO_SEL   8'h00
`define PSF_OFF_PA_HI_SEL   8'h04
`define PSF_OFF_PB_LO_SEL   8'h08
`define PSF_OFF_PB_HI_SEL   8'h0C
`define PSF_OFF_IN_SRC      8'h10
`define PSF_OFF_PA_DATA     8'h14
`define PSF_OFF_PA_DIR      8'h18
`define PSF_OFF_PA_WAKE     8'h1C
`define PSF_OFF_PB_DATA     8'h20
`define PSF_OFF_PB_DIR      8'h24
`define PSF_OFF_PA_BITOP    8'h28
`define PSF_OFF_PB_BITOP    8'h2C
`define PSF_OFF_SLEEP       8'h30
`define PSF_OFF_PA_PIN      8'h34
`define PSF_OFF_PB_PIN      8'h38
`define PSF_RST_SEL         8'h00
`define PSF_RST_PA_PORT     8'hFF
`define PSF_RST_PB_PORT     6'h3F
`define PSF_PB_HI_SEL_MASK  8'h0F
`define PSF_IN_SRC_MASK     8'h07
`define PSF_CODE_GPIO       2'h0
`define PSF_CODE_ALT1       2'h1
`define PSF_CODE_ALT2       2'h2
`define PSF_CODE_ALT3       2'h3
`define PSF_IFS_CAS_BIT     0
`define PSF_IFS_SCL_BIT     1
`define PSF_IFS_SDA_BIT     2
`define PSF_BITOP_SET_BIT   8
`define PSF_BITOP_IDX_LSB   0
`endif

// ==== psf_unused_none.v ====
// Intentionally empty: no further design files
`timescale 1ns/1ps
